// ===== usis_pkg.sv
// package for the serial transceiver interrupt and status block
package usis_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_IER = 8'h08;
  localparam logic [7:0] OFF_IDR = 8'h0C;
  localparam logic [7:0] OFF_IMR = 8'h10;
  localparam logic [7:0] OFF_CSR = 8'h14;
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_TOV = 8'h24;
  // ==========================================================
  // status bit positions
  localparam int B_RX_CHAR_READY = 0;
  localparam int B_TXFREE = 1;
  localparam int B_BRK = 2;
  localparam int B_RXEND = 3;
  localparam int B_TXEND = 4;
  localparam int B_OVR = 5;
  localparam int B_FRM = 6;
  localparam int B_PAR = 7;
  localparam int B_TMO = 8;
  localparam int B_TXEMP = 9;
  localparam int B_ITER = 10;
  localparam int B_TX_DMA_BUFFER_EMPTY = 11;
  localparam int B_RX_DMA_BUFFER_FULL = 12;
  localparam int B_NOT_ACKNOWLEDGED_FLAG = 13;
  localparam int B_CHG = 16;
  localparam int B_LVL = 20;
  // ==========================================================
  // command register bit positions (own layout)
  localparam int C_STATUS_CLR = 0;
  localparam int C_TMO_ARM = 1;
  localparam int C_ITER_CLR = 2;
  localparam int C_NOT_ACKNOWLEDGED_FLAG_CLR = 3;
  localparam int C_RX_EN = 4;
  localparam int C_RX_DIS = 5;
  localparam int C_TX_EN = 6;
  localparam int C_TX_DIS = 7;
  localparam int C_BRK_START = 8;
  localparam int C_BRK_STOP = 9;
  // ==========================================================
  localparam logic [31:0] MASK_FULL = 32'h000F3FFF;
  localparam logic [31:0] MASK_SMALL = 32'h00083FFF;
  localparam logic [31:0] MASK_RST = 32'h00000000;
  localparam logic [15:0] TOV_RST = 16'h0000;
  localparam logic [3:0] MODEM_RST = 4'hF;

  // receiver and transmitter events from the datapath
  typedef struct packed {
    logic char_done;
    logic holding_read;
    logic brk_edge;
    logic overrun;
    logic frame_err;
    logic parity_err;
    logic timeout_hit;
    logic iter_max;
    logic not_acknowledged_flag;
  } usis_rx_ev_t;

  typedef struct packed {
    logic holding_full;
    logic shift_busy;
  } usis_tx_st_t;

  typedef struct packed {
    logic rx_end;
    logic tx_end;
    logic tx_buf_empty;
    logic rx_buf_full;
  } usis_dma_t;
endpackage

// ===== usis_top.sv
// interrupt, mask and channel status logic of a serial transceiver, with apb slave
// ==========================================================
// Behaviour
// - write-only set register enables sources at bits 0..13 and 16..19
// - write-only clear register disables sources at the same positions
// - read-only mask view shows which sources are enabled
// - char ready sets on character, clears on read or receiver disable
// - holding free low when full, break pending or transmitter disabled
// - break flag latched on break or break end until status clear
// - dma end bits follow dma end signals unlatched
// - overrun flag latched until status clear
// - framing flag latched on low stop bit until status clear
// - parity flag latched until status clear
// - timeout flag set on expiry after arm; clear while value zero
// - all drained only when holding and shift empty and tx enabled
// - iteration flag latched until iteration clear command
// - dma buffer bits follow dma buffer signals
// - not acknowledged flag latched until its clear command
// - modem change flags set on pin change, cleared by status read
// - status bits 20..23 show synchronised modem input levels, two cycles behind the pins
// - reduced build keeps only the send permit change flag
`timescale 1ns/1ps
`default_nettype none
module usis_top #(
  parameter bit FULL_MODEM = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire usis_pkg::usis_rx_ev_t rx_ev,
  input wire usis_pkg::usis_tx_st_t tx_st,
  input wire usis_pkg::usis_dma_t dma,
  input wire logic call_alert_level,
  input wire logic peer_set_ready_level,
  input wire logic carrier_sense_level,
  input wire logic send_permit_level,
  output logic rx_enabled,
  output logic tx_enabled,
  output logic break_pending,
  output logic timeout_armed_pulse,
  output logic [15:0] timeout_value,
  output logic irq
);
  // ==========================================================
  // bus decode
  localparam logic [31:0] SRC_MASK = FULL_MODEM ? usis_pkg::MASK_FULL : usis_pkg::MASK_SMALL;
  logic wr_en, rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;

  logic hit;
  always_comb begin
    case (paddr)
      usis_pkg::OFF_IER, usis_pkg::OFF_IDR, usis_pkg::OFF_IMR, usis_pkg::OFF_CSR,
      usis_pkg::OFF_CMD, usis_pkg::OFF_TOV: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !hit;

  logic wr_ier, wr_idr, wr_cmd, wr_tov, rd_csr;
  assign wr_ier = wr_en && paddr == usis_pkg::OFF_IER;
  assign wr_idr = wr_en && paddr == usis_pkg::OFF_IDR;
  assign wr_cmd = wr_en && paddr == usis_pkg::OFF_CMD;
  assign wr_tov = wr_en && paddr == usis_pkg::OFF_TOV;
  assign rd_csr = rd_en && paddr == usis_pkg::OFF_CSR;

  logic [31:0] cmd;
  assign cmd = wr_cmd ? pwdata : 32'h00000000;

  // ==========================================================
  // modem pin synchronisers
  logic [3:0] modem_pin, sync1_reg, sync2_reg, last_reg;
  assign modem_pin = {send_permit_level, carrier_sense_level, peer_set_ready_level, call_alert_level};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= usis_pkg::MODEM_RST;
      sync2_reg <= usis_pkg::MODEM_RST;
      last_reg <= usis_pkg::MODEM_RST;
    end else begin
      sync1_reg <= modem_pin;
      sync2_reg <= sync1_reg;
      last_reg <= sync2_reg;
    end
  end

  // ==========================================================
  // control, mask and sticky flags
  logic [31:0] mask_reg, mask_next;
  logic [15:0] tov_reg, tov_next;
  logic rx_en_reg, rx_en_next, tx_en_reg, tx_en_next, brk_reg, brk_next;
  logic rdy_reg, rdy_next, pend_reg, pend_next;
  logic brk_f_reg, brk_f_next, ovr_reg, ovr_next, frm_reg, frm_next, par_reg, par_next;
  logic tmo_reg, tmo_next, arm_reg, arm_next, iter_reg, iter_next, not_acknowledged_flag_reg, not_acknowledged_flag_next;
  logic [3:0] chg_reg, chg_next;

  always_comb begin
    mask_next = mask_reg;
    if (wr_ier) begin
      mask_next = mask_reg | (pwdata & SRC_MASK);
    end
    if (wr_idr) begin
      mask_next = mask_reg & ~(pwdata & SRC_MASK);
    end
    tov_next = wr_tov ? pwdata[15:0] : tov_reg;
    rx_en_next = rx_en_reg;
    if (cmd[usis_pkg::C_RX_EN]) rx_en_next = 1'b1;
    if (cmd[usis_pkg::C_RX_DIS]) rx_en_next = 1'b0;
    tx_en_next = tx_en_reg;
    if (cmd[usis_pkg::C_TX_EN]) tx_en_next = 1'b1;
    if (cmd[usis_pkg::C_TX_DIS]) tx_en_next = 1'b0;
    brk_next = brk_reg;
    if (cmd[usis_pkg::C_BRK_START]) brk_next = 1'b1;
    if (cmd[usis_pkg::C_BRK_STOP]) brk_next = 1'b0;
    // characters completing while disabled are remembered and shown again on enable
    pend_next = pend_reg;
    if (rx_ev.char_done) pend_next = 1'b1;
    if (rx_ev.holding_read) pend_next = 1'b0;
    rdy_next = rx_en_next && pend_next;
    // sticky flags: set wins over a same-cycle clear, except that a zero timeout value clears the timeout flag
    brk_f_next = (brk_f_reg && !cmd[usis_pkg::C_STATUS_CLR]) || rx_ev.brk_edge;
    ovr_next = (ovr_reg && !cmd[usis_pkg::C_STATUS_CLR]) || rx_ev.overrun;
    frm_next = (frm_reg && !cmd[usis_pkg::C_STATUS_CLR]) || rx_ev.frame_err;
    par_next = (par_reg && !cmd[usis_pkg::C_STATUS_CLR]) || rx_ev.parity_err;
    arm_next = (arm_reg || cmd[usis_pkg::C_TMO_ARM]) && !rx_ev.timeout_hit;
    tmo_next = tmo_reg && !cmd[usis_pkg::C_TMO_ARM];
    if (rx_ev.timeout_hit && arm_reg) tmo_next = 1'b1;
    if (tov_next == usis_pkg::TOV_RST) tmo_next = 1'b0;
    iter_next = (iter_reg && !cmd[usis_pkg::C_ITER_CLR]) || rx_ev.iter_max;
    not_acknowledged_flag_next = (not_acknowledged_flag_reg && !cmd[usis_pkg::C_NOT_ACKNOWLEDGED_FLAG_CLR]) || rx_ev.not_acknowledged_flag;
    chg_next = (rd_csr ? 4'h0 : chg_reg) | ((sync2_reg ^ last_reg) & SRC_MASK[19:16]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= usis_pkg::MASK_RST;
      tov_reg <= usis_pkg::TOV_RST;
      rx_en_reg <= 1'b0;
      tx_en_reg <= 1'b0;
      brk_reg <= 1'b0;
      pend_reg <= 1'b0;
      rdy_reg <= 1'b0;
      brk_f_reg <= 1'b0;
      ovr_reg <= 1'b0;
      frm_reg <= 1'b0;
      par_reg <= 1'b0;
      tmo_reg <= 1'b0;
      arm_reg <= 1'b0;
      iter_reg <= 1'b0;
      not_acknowledged_flag_reg <= 1'b0;
      chg_reg <= 4'h0;
    end else begin
      mask_reg <= mask_next;
      tov_reg <= tov_next;
      rx_en_reg <= rx_en_next;
      tx_en_reg <= tx_en_next;
      brk_reg <= brk_next;
      pend_reg <= pend_next;
      rdy_reg <= rdy_next;
      brk_f_reg <= brk_f_next;
      ovr_reg <= ovr_next;
      frm_reg <= frm_next;
      par_reg <= par_next;
      tmo_reg <= tmo_next;
      arm_reg <= arm_next;
      iter_reg <= iter_next;
      not_acknowledged_flag_reg <= not_acknowledged_flag_next;
      chg_reg <= chg_next;
    end
  end

  // ==========================================================
  // status word
  logic [31:0] status;
  always_comb begin
    status = 32'h00000000;
    status[usis_pkg::B_RX_CHAR_READY] = rdy_reg;
    status[usis_pkg::B_TXFREE] = tx_en_reg && !tx_st.holding_full && !brk_reg;
    status[usis_pkg::B_BRK] = brk_f_reg;
    status[usis_pkg::B_RXEND] = dma.rx_end;
    status[usis_pkg::B_TXEND] = dma.tx_end;
    status[usis_pkg::B_OVR] = ovr_reg;
    status[usis_pkg::B_FRM] = frm_reg;
    status[usis_pkg::B_PAR] = par_reg;
    status[usis_pkg::B_TMO] = tmo_reg;
    status[usis_pkg::B_TXEMP] = tx_en_reg && !tx_st.holding_full && !tx_st.shift_busy;
    status[usis_pkg::B_ITER] = iter_reg;
    status[usis_pkg::B_TX_DMA_BUFFER_EMPTY] = dma.tx_buf_empty;
    status[usis_pkg::B_RX_DMA_BUFFER_FULL] = dma.rx_buf_full;
    status[usis_pkg::B_NOT_ACKNOWLEDGED_FLAG] = not_acknowledged_flag_reg;
    status[usis_pkg::B_CHG +: 4] = chg_reg;
    status[usis_pkg::B_LVL +: 4] = sync2_reg;
  end

  // ==========================================================
  // read data and outputs; read data registered at the setup edge
  logic [31:0] rdata_next, rdata_reg;
  logic irq_reg;
  always_comb begin
    rdata_next = rdata_reg;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        usis_pkg::OFF_IMR: rdata_next = mask_reg;
        usis_pkg::OFF_CSR: rdata_next = status;
        usis_pkg::OFF_TOV: rdata_next = {16'h0000, tov_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h00000000;
      irq_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      irq_reg <= |(status & mask_reg);
    end
  end
  assign prdata = rdata_reg;
  assign irq = irq_reg;
  assign rx_enabled = rx_en_reg;
  assign tx_enabled = tx_en_reg;
  assign break_pending = brk_reg;
  assign timeout_armed_pulse = cmd[usis_pkg::C_TMO_ARM];
  assign timeout_value = tov_reg;
endmodule
`default_nettype wire

// ===== usis_top_sva.sv
// checker for the interrupt and status block ports
`timescale 1ns/1ps
`default_nettype none
module usis_top_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic rx_enabled,
  input wire logic tx_enabled,
  input wire logic break_pending,
  input wire logic timeout_armed_pulse,
  input wire logic [15:0] timeout_value,
  input wire logic irq
);
  // ==========================================================
  // helpers
  logic acc;
  logic wr;
  logic cmd;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign cmd = wr && paddr == usis_pkg::OFF_CMD;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // assertions
  a_arm_pulse: assert property (timeout_armed_pulse == (cmd && pwdata[1]))
    else $error("arm pulse mismatch");
  a_tov_zero: assert property (wr && paddr == usis_pkg::OFF_TOV && pwdata[15:0] == 16'h0000 |=> timeout_value == 16'h0000)
    else $error("timeout value not zero");
  a_rx_on: assert property (cmd && pwdata[4] && !pwdata[5] |=> rx_enabled)
    else $error("receiver not enabled");
  a_rx_off: assert property (cmd && pwdata[5] |=> !rx_enabled)
    else $error("receiver not disabled");
  a_tx_off: assert property (cmd && pwdata[7] |=> !tx_enabled)
    else $error("transmitter not disabled");
  a_brk_set: assert property (cmd && pwdata[8] && !pwdata[9] |=> break_pending)
    else $error("break not pending");
  a_irq_drop: assert property (wr && paddr == usis_pkg::OFF_IDR && pwdata == 32'hFFFFFFFF |-> ##2 !irq)
    else $error("irq high with all masks clear");
  a_mask_bits: assert property (acc && !pwrite && paddr == usis_pkg::OFF_IMR |-> (prdata & ~usis_pkg::MASK_FULL) == 32'h0)
    else $error("mask view has reserved bits");
  a_unmapped_err: assert property (acc && !(paddr inside {8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h24}) |-> pslverr)
    else $error("no error on unmapped address");
  c_irq: cover property (irq);
  c_rx_on: cover property (rx_enabled);
  c_err: cover property (acc && pslverr);
endmodule
bind usis_top usis_top_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .rx_enabled(rx_enabled),
  .tx_enabled(tx_enabled), .break_pending(break_pending), .timeout_armed_pulse(timeout_armed_pulse),
  .timeout_value(timeout_value), .irq(irq));
`default_nettype wire

// ===== usis_peer.sv
// modem peer: drives the four handshake levels, promptly or one cycle late
`timescale 1ns/1ps
`default_nettype none
module usis_peer (
  input wire logic pclk,
  input wire logic slow,
  input wire logic [3:0] req,
  output logic [3:0] lvl
);
  logic [3:0] d1;
  initial d1 = 4'hF;
  initial lvl = 4'hF;
  always @(posedge pclk) begin
    d1 <= req;
    lvl <= slow ? d1 : req;
  end
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench of the interrupt and status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, pready, pslverr, irq, perr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, m, v, w;
  logic [15:0] tov;
  logic [3:0] lreq = 4'hF, lvl;
  usis_pkg::usis_rx_ev_t rx_ev = '0;
  usis_pkg::usis_tx_st_t tx_st = '0;
  usis_pkg::usis_dma_t dma = '0;
  int n_errors = 0, compares = 0, seed = 51830;
  int fb[4] = '{7, 6, 5, 2};
  usis_top i_usis_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_ev(rx_ev),
    .tx_st(tx_st), .dma(dma), .call_alert_level(lvl[0]), .peer_set_ready_level(lvl[1]),
    .carrier_sense_level(lvl[2]), .send_permit_level(lvl[3]), .rx_enabled(), .tx_enabled(),
    .break_pending(), .timeout_armed_pulse(), .timeout_value(tov), .irq(irq));
  usis_peer i_usis_peer (.pclk(pclk), .slow(slow), .req(lreq), .lvl(lvl));
  initial forever #4 pclk = ~pclk;
  // ==========================================================
  // tasks
  task automatic test_done;
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // request held until pready is sampled high
  task automatic apb(input logic wn, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wn;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd_csr;
    apb(0, usis_pkg::OFF_CSR, 32'h0);
  endtask
  task automatic ev(input int k);
    @(posedge pclk);
    rx_ev <= 9'(1 << k);
    @(posedge pclk);
    rx_ev <= '0;
  endtask
  // ==========================================================
  // watchdog
  initial begin
    #200000;
    n_errors++;
    test_done();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(0, usis_pkg::OFF_IMR, 32'h0);
    chk("mask_reset", r, usis_pkg::MASK_RST);
    m = 32'h0;
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 32'hFFFFFFFF : $random(seed);
      w = (i == 0) ? 32'h0 : $random(seed);
      apb(1, usis_pkg::OFF_IER, v);
      m = m | (v & usis_pkg::MASK_FULL);
      apb(1, usis_pkg::OFF_IDR, w);
      m = m & ~w;
      apb(0, usis_pkg::OFF_IMR, 32'h0);
      chk("mask", r, m);
    end
    apb(1, usis_pkg::OFF_IDR, 32'hFFFFFFFF);
    for (int i = 0; i < 4; i++) begin
      ev(i + 3);
      rd_csr();
      chk("sticky", 32'(r[fb[i]]), 32'h1);
    end
    ev(0);
    apb(1, usis_pkg::OFF_CMD, 32'h1);
    rd_csr();
    chk("sticky_clr", r & 32'h000020E4, 32'h00002000);
    apb(1, usis_pkg::OFF_CMD, 32'h8);
    rd_csr();
    chk("not_acknowledged_flag_clr", 32'(r[13]), 32'h0);
    ev(5);
    apb(1, usis_pkg::OFF_IER, 32'h20);
    repeat (2) @(posedge pclk);
    chk("irq_on", 32'(irq), 32'h1);
    apb(1, usis_pkg::OFF_IDR, 32'hFFFFFFFF);
    repeat (2) @(posedge pclk);
    chk("irq_off", 32'(irq), 32'h0);
    apb(1, usis_pkg::OFF_CMD, 32'h10);
    ev(8);
    rd_csr();
    chk("char_ready", 32'(r[0]), 32'h1);
    ev(7);
    rd_csr();
    chk("char_read", 32'(r[0]), 32'h0);
    ev(8);
    apb(1, usis_pkg::OFF_CMD, 32'h20);
    rd_csr();
    chk("rx_off", 32'(r[0]), 32'h0);
    apb(1, usis_pkg::OFF_CMD, 32'h10);
    rd_csr();
    chk("rx_reenable", 32'(r[0]), 32'h1);
    ev(1);
    rd_csr();
    chk("iteration", 32'(r[10]), 32'h1);
    apb(1, usis_pkg::OFF_CMD, 32'h4);
    rd_csr();
    chk("iteration_clr", 32'(r[10]), 32'h0);
    apb(1, usis_pkg::OFF_CMD, 32'h40);
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk);
      tx_st <= 2'(i);
      rd_csr();
      chk("tx_state", 32'({r[9], r[1]}), (i == 0) ? 32'h3 : (i == 1) ? 32'h1 : 32'h0);
    end
    tx_st <= '0;
    apb(1, usis_pkg::OFF_CMD, 32'h100);
    rd_csr();
    chk("brk_pending", 32'(r[1]), 32'h0);
    apb(1, usis_pkg::OFF_CMD, 32'h280);
    rd_csr();
    chk("tx_off", 32'({r[9], r[1]}), 32'h0);
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      dma <= 4'($random(seed));
      rd_csr();
      chk("dma", 32'({r[3], r[4], r[11], r[12]}), 32'(dma));
    end
    for (int i = 0; i < 4; i++) begin
      slow <= i[0];
      lreq <= lreq ^ 4'(1 << i);
      repeat (6) @(posedge pclk);
      rd_csr();
      chk("modem", 32'(r[23:16]), 32'({lreq, 4'(1 << i)}));
      rd_csr();
      chk("modem_clr", 32'(r[19:16]), 32'h0);
    end
    apb(1, usis_pkg::OFF_TOV, 32'h5);
    apb(1, usis_pkg::OFF_CMD, 32'h2);
    ev(2);
    rd_csr();
    chk("timeout", 32'(r[8]), 32'h1);
    apb(1, usis_pkg::OFF_TOV, 32'h0);
    rd_csr();
    chk("timeout_zero", 32'({tov, 15'h0, r[8]}), 32'h0);
    apb(0, 8'h40, 32'h0);
    chk("unmapped", {perr, r[30:0]}, 32'h80000000);
    test_done();
  end
endmodule
`default_nettype wire
